// >>> inc/dcd_pkg.sv
// constants and types of the display configuration command decoder
// assumes one 25 MHz clock and a classic wishbone register port
package dcd_pkg;
  // register port
  localparam int          ADR_W      = 8;
  localparam int          DAT_W      = 32;
  localparam logic [7:0]  ADR_CMD    = 8'h00;
  localparam logic [7:0]  ADR_ADDR   = 8'h04;
  localparam logic [7:0]  ADR_PANEL  = 8'h08;
  localparam logic [7:0]  ADR_TIMING = 8'h0c;
  localparam logic [7:0]  ADR_SCROLL = 8'h10;
  // opcodes
  localparam logic [7:0]  OP_VSA     = 8'ha3;
  localparam logic [7:0]  OP_MODE    = 8'h20;
  localparam logic [7:0]  OP_COLW    = 8'h21;
  localparam logic [7:0]  OP_PAGEW   = 8'h22;
  localparam logic [7:0]  OP_SEGN    = 8'ha0;
  localparam logic [7:0]  OP_SEGR    = 8'ha1;
  localparam logic [7:0]  OP_MUX     = 8'ha8;
  localparam logic [7:0]  OP_SCANN   = 8'hc0;
  localparam logic [7:0]  OP_SCANR   = 8'hc8;
  localparam logic [7:0]  OP_OFFS    = 8'hd3;
  localparam logic [7:0]  OP_PINS    = 8'hda;
  localparam logic [7:0]  OP_CLK     = 8'hd5;
  localparam logic [7:0]  OP_PRE     = 8'hd9;
  localparam logic [7:0]  OP_VCOM    = 8'hdb;
  localparam logic [7:0]  OP_NOP     = 8'he3;
  localparam logic [7:0]  OP_CONTR   = 8'h81;
  localparam logic [7:0]  OP_PUMP    = 8'h8d;
  localparam logic [7:0]  OP_HSR     = 8'h26;
  localparam logic [7:0]  OP_HSL     = 8'h27;
  localparam logic [7:0]  OP_VHR     = 8'h29;
  localparam logic [7:0]  OP_VHL     = 8'h2a;
  // opcode groups that carry data in their low bits
  localparam logic [3:0]  GRP_COL_LO = 4'h0;
  localparam logic [3:0]  GRP_COL_HI = 4'h1;
  localparam logic [1:0]  GRP_LINE   = 2'b01;
  localparam logic [4:0]  GRP_PAGE   = 5'b10110;
  // parameter byte counts
  localparam logic [2:0]  PC_NONE    = 3'h0;
  localparam logic [2:0]  PC_ONE     = 3'h1;
  localparam logic [2:0]  PC_TWO     = 3'h2;
  localparam logic [2:0]  PC_FIVE    = 3'h5;
  localparam logic [2:0]  PC_SIX     = 3'h6;
  // reset values and limits
  localparam logic [5:0]  RST_FIXED  = 6'h00;
  localparam logic [6:0]  RST_SCROLL = 7'h40;
  localparam logic [1:0]  MODE_HORIZ = 2'b00;
  localparam logic [1:0]  MODE_PAGE  = 2'b10;
  localparam logic [1:0]  MODE_BAD   = 2'b11;
  localparam logic [6:0]  RST_COL_E  = 7'h7f;
  localparam logic [2:0]  RST_PAGE_E = 3'h7;
  localparam logic [5:0]  RST_MUX    = 6'h3f;
  localparam logic [5:0]  MUX_MIN    = 6'h0f;
  localparam logic        RST_ALT    = 1'b1;
  localparam logic [3:0]  RST_DIV    = 4'h0;
  localparam logic [3:0]  RST_OSC    = 4'h8;
  localparam logic [3:0]  RST_PRE    = 4'h2;
  localparam logic [3:0]  PRE_BAD    = 4'h0;
  localparam logic [2:0]  VCOM_LO    = 3'b000;
  localparam logic [2:0]  VCOM_MID   = 3'b010;
  localparam logic [2:0]  VCOM_HI    = 3'b011;
  // decoder states, gray coded
  typedef enum logic [1:0] {
    DCD_S_OPC = 2'b00,
    DCD_S_PAR = 2'b01
  } dcd_state_e;
endpackage

// >>> inc/dcd_scroll_if.sv
// signals between the decoder and the scroll row mapper
// assumes both ends run on the decoder clock
`timescale 1ns/1ps
interface dcd_scroll_if;
  logic [5:0] fixed_rows;
  logic [6:0] scroll_rows;
  logic       step;
  logic [5:0] row;
  logic [5:0] mem_row;
  logic [5:0] offset;
  modport ctrl (output fixed_rows, scroll_rows, step, row,
                input  mem_row, offset);
  modport map  (input  fixed_rows, scroll_rows, step, row,
                output mem_row, offset);
endinterface

// >>> src/dcd_scroll_map.sv
// vertical scroll row mapper: wraps rows inside the scroll area
// assumes synchronous active high reset and one clock
`timescale 1ns/1ps
module dcd_scroll_map (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // decoder side
  dcd_scroll_if.map sc
);
  import dcd_pkg::*;

  logic [5:0] off_r;
  logic [5:0] mem_row_r;
  logic [7:0] rel;
  logic [7:0] sum;
  logic [7:0] area;
  logic [5:0] off_eff;
  logic       in_area;

  assign area    = {1'b0, sc.scroll_rows};
  assign off_eff = ({2'h0, off_r} < area) ? off_r : 6'h00;

  // offset advances one row per step, last row wraps to first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_r <= 6'h00;
    end else if (sc.step) begin
      if ({2'h0, off_r} + 8'h01 >= area) begin
        off_r <= 6'h00;
      end else begin
        off_r <= off_r + 6'h01;
      end
    end
  end

  always_comb begin
    rel     = {2'h0, sc.row} - {2'h0, sc.fixed_rows};
    in_area = (sc.row >= sc.fixed_rows) && (rel < area);
    sum     = rel + area - {2'h0, off_eff};
    if (sum >= area) begin
      sum = sum - area;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_row_r <= 6'h00;
    end else if (in_area) begin
      mem_row_r <= sc.fixed_rows + sum[5:0];
    end else begin
      mem_row_r <= sc.row;
    end
  end

  assign sc.mem_row = mem_row_r;
  assign sc.offset  = off_r;

  a_wrap_last_row: assert property (@(posedge clk_i) disable iff (rst_i)
    sc.step && ({2'h0, off_r} + 8'h01 == area) |=> off_r == 6'h00)
    else $error("scroll offset did not wrap to the first row");

endmodule // dcd_scroll_map

// >>> src/dcd_top.sv
// display configuration command decoder with a wishbone register port
// assumes a classic wishbone master and synchronous reset on clk_i
`timescale 1ns/1ps
module dcd_top (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [dcd_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [dcd_pkg::DAT_W-1:0]  wb_dat_i,
  output wire logic [dcd_pkg::DAT_W-1:0]  wb_dat_o,
  output wire logic                       wb_ack_o,
  // addressing settings
  output wire logic [1:0]                 addr_mode_o,
  output wire logic [7:0]                 page_col_o,
  output wire logic [2:0]                 page_sel_o,
  output wire logic [6:0]                 col_start_o,
  output wire logic [6:0]                 col_end_o,
  output wire logic [2:0]                 page_start_o,
  output wire logic [2:0]                 page_end_o,
  // panel settings
  output wire logic [5:0]                 start_line_o,
  output wire logic                       seg_remap_o,
  output wire logic [5:0]                 mux_ratio_o,
  output wire logic                       com_scan_rev_o,
  output wire logic [5:0]                 disp_offset_o,
  output wire logic                       com_alt_o,
  output wire logic                       com_lr_remap_o,
  // timing settings
  output wire logic [3:0]                 clk_div_o,
  output wire logic [3:0]                 osc_freq_o,
  output wire logic [3:0]                 pre_phase1_o,
  output wire logic [3:0]                 pre_phase2_o,
  output wire logic [2:0]                 vcom_sel_o,
  // vertical scroll area and row mapping
  output wire logic [5:0]                 fixed_rows_o,
  output wire logic [6:0]                 scroll_rows_o,
  input  wire logic                       scroll_step_i,
  input  wire logic [5:0]                 row_i,
  output wire logic [5:0]                 mem_row_o
);
  import dcd_pkg::*;

  dcd_scroll_if sc ();

  dcd_state_e         st_r;
  logic [7:0]         op_r;
  logic [2:0]         left_r;
  logic [2:0]         idx_r;
  logic               ack_r;
  logic [DAT_W-1:0]   dat_r;
  logic [DAT_W-1:0]   rd_data;
  logic               req;
  logic               wr_cmd;
  logic               is_op;
  logic               is_par;
  logic [7:0]         b;
  logic [1:0]         mode_r;
  logic [7:0]         page_col_r;
  logic [2:0]         page_sel_r;
  logic [6:0]         col_start_r;
  logic [6:0]         col_end_r;
  logic [2:0]         page_start_r;
  logic [2:0]         page_end_r;
  logic [5:0]         start_line_r;
  logic               seg_remap_r;
  logic [5:0]         mux_r;
  logic               scan_rev_r;
  logic [5:0]         offset_r;
  logic               com_alt_r;
  logic               com_lr_r;
  logic [3:0]         div_r;
  logic [3:0]         osc_r;
  logic [3:0]         pre1_r;
  logic [3:0]         pre2_r;
  logic [2:0]         vcom_r;
  logic [5:0]         fixed_r;
  logic [6:0]         scroll_r;

  // number of parameter bytes that follow an opcode
  function automatic logic [2:0] param_count(input logic [7:0] op);
    case (op)
      OP_VSA, OP_COLW, OP_PAGEW: param_count = PC_TWO;
      OP_MODE, OP_MUX, OP_OFFS, OP_PINS, OP_CLK, OP_PRE, OP_VCOM,
      OP_CONTR, OP_PUMP: param_count = PC_ONE;
      OP_HSR, OP_HSL: param_count = PC_SIX;
      OP_VHR, OP_VHL: param_count = PC_FIVE;
      default: param_count = PC_NONE;
    endcase
  endfunction

  // true when parameter byte i of opcode op is on the bus
  function automatic logic par_at(input logic [7:0] op,
                                  input logic [2:0] i);
    par_at = is_par && (op_r == op) && (idx_r == i);
  endfunction

  // bus slave: one wait state, ack for one cycle
  assign req    = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_cmd = req && wb_we_i && (wb_adr_i == ADR_CMD) && wb_sel_i[0];
  assign b      = wb_dat_i[7:0];
  assign is_op  = wr_cmd && (st_r == DCD_S_OPC);
  assign is_par = wr_cmd && (st_r == DCD_S_PAR);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_comb begin
    case (wb_adr_i)
      ADR_CMD:    rd_data = {16'h0000, 1'b0, page_sel_r, left_r,
                             (st_r == DCD_S_PAR), page_col_r};
      ADR_ADDR:   rd_data = {8'h00, mode_r, page_end_r, page_start_r,
                             1'b0, col_end_r, 1'b0, col_start_r};
      ADR_PANEL:  rd_data = {10'h000, com_lr_r, com_alt_r, offset_r,
                             scan_rev_r, mux_r, seg_remap_r,
                             start_line_r};
      ADR_TIMING: rd_data = {13'h0000, vcom_r, pre2_r, pre1_r, osc_r,
                             div_r};
      ADR_SCROLL: rd_data = {13'h0000, sc.offset, scroll_r, fixed_r};
      default:    rd_data = {DAT_W{1'b0}};
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= {DAT_W{1'b0}};
    end else if (req && !wb_we_i) begin
      dat_r <= rd_data;
    end
  end

  // command sequencer: opcode, then counted parameter bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r   <= DCD_S_OPC;
      op_r   <= 8'h00;
      left_r <= PC_NONE;
      idx_r  <= PC_NONE;
    end else if (wr_cmd) begin
      case (st_r)
        DCD_S_OPC: begin
          op_r   <= b;
          left_r <= param_count(b);
          idx_r  <= PC_NONE;
          st_r   <= (param_count(b) != PC_NONE) ? DCD_S_PAR : DCD_S_OPC;
        end
        DCD_S_PAR: begin
          idx_r  <= idx_r + PC_ONE;
          left_r <= left_r - PC_ONE;
          if (left_r == PC_ONE) begin
            st_r <= DCD_S_OPC;
          end
        end
        default: st_r <= DCD_S_OPC;
      endcase
    end
  end

  // addressing settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r       <= MODE_PAGE;
      page_col_r   <= 8'h00;
      page_sel_r   <= 3'h0;
      col_start_r  <= 7'h00;
      col_end_r    <= RST_COL_E;
      page_start_r <= 3'h0;
      page_end_r   <= RST_PAGE_E;
    end else if (is_op) begin
      if (b[7:4] == GRP_COL_LO) begin
        page_col_r[3:0] <= b[3:0];
      end else if (b[7:4] == GRP_COL_HI) begin
        page_col_r[7:4] <= b[3:0];
      end else if (b[7:3] == GRP_PAGE) begin
        page_sel_r <= b[2:0];
      end
    end else if (par_at(OP_MODE, PC_NONE) && b[1:0] != MODE_BAD) begin
      mode_r <= b[1:0];
    end else if (par_at(OP_COLW, PC_NONE)) begin
      col_start_r <= b[6:0];
    end else if (par_at(OP_COLW, PC_ONE)) begin
      col_end_r <= b[6:0];
    end else if (par_at(OP_PAGEW, PC_NONE)) begin
      page_start_r <= b[2:0];
    end else if (par_at(OP_PAGEW, PC_ONE)) begin
      page_end_r <= b[2:0];
    end
  end

  // panel layout settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_line_r <= 6'h00;
      seg_remap_r  <= 1'b0;
      mux_r        <= RST_MUX;
      scan_rev_r   <= 1'b0;
      offset_r     <= 6'h00;
      com_alt_r    <= RST_ALT;
      com_lr_r     <= 1'b0;
    end else if (is_op) begin
      if (b[7:6] == GRP_LINE) begin
        start_line_r <= b[5:0];
      end
      case (b)
        OP_SEGN:  seg_remap_r <= 1'b0;
        OP_SEGR:  seg_remap_r <= 1'b1;
        OP_SCANN: scan_rev_r  <= 1'b0;
        OP_SCANR: scan_rev_r  <= 1'b1;
        default:  seg_remap_r <= seg_remap_r;
      endcase
    end else if (par_at(OP_MUX, PC_NONE) && b[5:0] >= MUX_MIN) begin
      mux_r <= b[5:0];
    end else if (par_at(OP_OFFS, PC_NONE)) begin
      offset_r <= b[5:0];
    end else if (par_at(OP_PINS, PC_NONE)) begin
      com_alt_r <= b[4];
      com_lr_r  <= b[5];
    end
  end

  // timing and driving settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r  <= RST_DIV;
      osc_r  <= RST_OSC;
      pre1_r <= RST_PRE;
      pre2_r <= RST_PRE;
      vcom_r <= VCOM_MID;
    end else if (par_at(OP_CLK, PC_NONE)) begin
      div_r <= b[3:0];
      osc_r <= b[7:4];
    end else if (par_at(OP_PRE, PC_NONE)) begin
      if (b[3:0] != PRE_BAD) begin
        pre1_r <= b[3:0];
      end
      if (b[7:4] != PRE_BAD) begin
        pre2_r <= b[7:4];
      end
    end else if (par_at(OP_VCOM, PC_NONE)) begin
      if (b[6:4] == VCOM_LO || b[6:4] == VCOM_MID || b[6:4] == VCOM_HI) begin
        vcom_r <= b[6:4];
      end
    end
  end

  // vertical scroll area
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fixed_r  <= RST_FIXED;
      scroll_r <= RST_SCROLL;
    end else if (par_at(OP_VSA, PC_NONE)) begin
      fixed_r <= b[5:0];
    end else if (par_at(OP_VSA, PC_ONE)) begin
      scroll_r <= b[6:0];
    end
  end

  // row wrap inside the scroll area, bounds kept by the host
  assign sc.fixed_rows  = fixed_r;
  assign sc.scroll_rows = scroll_r;
  assign sc.step        = scroll_step_i;
  assign sc.row         = row_i;

  dcd_scroll_map u_map (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sc    (sc)
  );

  assign wb_dat_o       = dat_r;
  assign wb_ack_o       = ack_r;
  assign addr_mode_o    = mode_r;
  assign page_col_o     = page_col_r;
  assign page_sel_o     = page_sel_r;
  assign col_start_o    = col_start_r;
  assign col_end_o      = col_end_r;
  assign page_start_o   = page_start_r;
  assign page_end_o     = page_end_r;
  assign start_line_o   = start_line_r;
  assign seg_remap_o    = seg_remap_r;
  assign mux_ratio_o    = mux_r;
  assign com_scan_rev_o = scan_rev_r;
  assign disp_offset_o  = offset_r;
  assign com_alt_o      = com_alt_r;
  assign com_lr_remap_o = com_lr_r;
  assign clk_div_o      = div_r;
  assign osc_freq_o     = osc_r;
  assign pre_phase1_o   = pre1_r;
  assign pre_phase2_o   = pre2_r;
  assign vcom_sel_o     = vcom_r;
  assign fixed_rows_o   = fixed_r;
  assign scroll_rows_o  = scroll_r;
  assign mem_row_o      = sc.mem_row;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_vsa_open;
    is_op && b == OP_VSA;
  endsequence

  sequence s_vsa_first;
    is_par && op_r == OP_VSA && idx_r == PC_NONE;
  endsequence

  a_vsa_first_byte: assert property (
    s_vsa_first |=> fixed_r == $past(b[5:0]) && scroll_r == $past(scroll_r))
    else $error("fixed row count not loaded from first parameter");

  a_vsa_second_byte: assert property (
    is_par && op_r == OP_VSA && idx_r == PC_ONE
    |=> scroll_r == $past(b[6:0]) && st_r == DCD_S_OPC)
    else $error("scroll row count not loaded from second parameter");

  a_param_count: assert property (
    s_vsa_open |=> st_r == DCD_S_PAR && left_r == PC_TWO
    && op_r == OP_VSA)
    else $error("parameter count not armed after opcode");

  a_col_nibbles: assert property (
    is_op && b[7:4] == GRP_COL_LO
    |=> page_col_r == {$past(page_col_r[7:4]), $past(b[3:0])})
    else $error("low column nibble not loaded");

  a_col_high: assert property (
    is_op && b[7:4] == GRP_COL_HI |=> page_col_r[7:4] == $past(b[3:0]))
    else $error("high column nibble not loaded");

  a_mode_invalid: assert property (
    par_at(OP_MODE, PC_NONE) && b[1:0] == MODE_BAD |=> $stable(mode_r))
    else $error("invalid addressing mode was stored");

  a_mode_valid: assert property (
    par_at(OP_MODE, PC_NONE) && b[1:0] != MODE_BAD
    |=> mode_r == $past(b[1:0]))
    else $error("addressing mode not stored");

  a_mux_range: assert property (
    par_at(OP_MUX, PC_NONE) |=> (($past(b[5:0]) < MUX_MIN) ?
    mux_r == $past(mux_r) : mux_r == $past(b[5:0])))
    else $error("multiplex ratio update wrong");

  a_start_line: assert property (
    is_op && b[7:6] == GRP_LINE |=> start_line_r == $past(b[5:0]))
    else $error("display start line not loaded");

  a_nop_quiet: assert property (
    is_op && b == OP_NOP |=> st_r == DCD_S_OPC && $stable(mode_r)
    && $stable(page_col_r) && $stable(start_line_r) && $stable(mux_r))
    else $error("no-operation changed a setting");

  a_ack_single: assert property (
    ack_r |=> !ack_r)
    else $error("bus acknowledge held longer than one cycle");

endmodule // dcd_top

// >>> verification/dcd_host.sv
// host model: classic wishbone master writing command bytes
// assumes a slave that answers each request with an ack
`timescale 1ns/1ps
module dcd_host (
  // clock
  input  wire logic        clk_i,
  // wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // one request, held until ack, then idle for a cycle
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] d, output logic [31:0] q);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hf;
    wb_dat_o <= d;
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1) @(posedge clk_i);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= ~we;
    wb_adr_o <= ~adr;
    wb_sel_o <= 4'h0;
    wb_dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // dcd_host

// >>> verification/test_display_config_command_decoder.sv
// bench: command stream, readback and scroll mapping against a model
// assumes dcd_top and the dcd_host wishbone master
`timescale 1ns/1ps
module test_display_config_command_decoder;
  logic        clk_i, rst_i, scroll_step_i, wb_ack_o, seg_remap_o;
  logic        com_scan_rev_o, com_alt_o, com_lr_remap_o;
  logic        wb_cyc_i, wb_stb_i, wb_we_i;
  logic [1:0]  addr_mode_o;
  logic [2:0]  page_sel_o, page_start_o, page_end_o, vcom_sel_o;
  logic [3:0]  wb_sel_i, clk_div_o, osc_freq_o, pre_phase1_o, pre_phase2_o;
  logic [5:0]  start_line_o, mux_ratio_o, disp_offset_o, fixed_rows_o;
  logic [5:0]  mem_row_o, row_i;
  logic [6:0]  col_start_o, col_end_o, scroll_rows_o;
  logic [7:0]  wb_adr_i, page_col_o, op, t;
  logic [31:0] wb_dat_i, wb_dat_o, q, rs;
  logic [7:0]  tbl [14];
  int md, pc, ps, cs, ce, pgs, pge, sl, seg, mx, scn, off, alt, lr;
  int dv, osc, p1, p2, vc, fx, sr, so, error_cnt, cmp_count;

  dcd_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .addr_mode_o,
    .page_col_o, .page_sel_o, .col_start_o, .col_end_o, .page_start_o,
    .page_end_o, .start_line_o, .seg_remap_o, .mux_ratio_o,
    .com_scan_rev_o, .disp_offset_o, .com_alt_o, .com_lr_remap_o,
    .clk_div_o, .osc_freq_o, .pre_phase1_o, .pre_phase2_o, .vcom_sel_o,
    .fixed_rows_o, .scroll_rows_o, .scroll_step_i, .row_i, .mem_row_o);
  dcd_host host_u (.clk_i, .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
    .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
    .wb_dat_o(wb_dat_i), .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o));

  always #20 clk_i = ~clk_i;

  function automatic logic [7:0] rb();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs[7:0];
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic check_all();
    #1;
    check_fields();
    @(posedge clk_i);
  endtask

  task automatic check_fields();
    chk(addr_mode_o, md);
    chk(page_col_o, pc);
    chk(page_sel_o, ps);
    chk(col_start_o, cs);
    chk(col_end_o, ce);
    chk(page_start_o, pgs);
    chk(page_end_o, pge);
    chk(start_line_o, sl);
    chk(seg_remap_o, seg);
    chk(mux_ratio_o, mx);
    chk(com_scan_rev_o, scn);
    chk(disp_offset_o, off);
    chk(com_alt_o, alt);
    chk(com_lr_remap_o, lr);
    chk(clk_div_o, dv);
    chk(osc_freq_o, osc);
    chk(pre_phase1_o, p1);
    chk(pre_phase2_o, p2);
    chk(vcom_sel_o, vc);
    chk(fixed_rows_o, fx);
    chk(scroll_rows_o, sr);
  endtask

  // send opcode and its parameter bytes, then update the model
  task automatic cmd(input logic [7:0] o, input logic [7:0] a, b);
    int n;
    n = (o inside {8'ha3, 8'h21, 8'h22}) ? 2 :
        (o inside {8'h26, 8'h27}) ? 6 : (o inside {8'h29, 8'h2a}) ? 5 :
        (o inside {8'h20, 8'ha8, 8'hd3, 8'hda, 8'hd5, 8'hd9, 8'hdb,
                   8'h81, 8'h8d});
    host_u.xfer(1'b1, 8'h00, {24'h0, o}, q);
    for (int k = 0; k < n; k++)
      host_u.xfer(1'b1, 8'h00, {24'h0, (k == 0) ? a : b}, q);
    if (o < 8'h10) pc = (pc & 'hf0) | o[3:0];
    else if (o < 8'h20) pc = (pc & 'h0f) | (o[3:0] << 4);
    else if (o[7:6] == 2'b01) sl = o[5:0];
    else if (o[7:3] == 5'b10110) ps = o[2:0];
    else case (o)
      8'h20: if (a[1:0] != 2'b11) md = a[1:0];
      8'h21: begin cs = a[6:0]; ce = b[6:0]; end
      8'h22: begin pgs = a[2:0]; pge = b[2:0]; end
      8'ha0, 8'ha1: seg = o[0];
      8'ha3: begin fx = a[5:0]; sr = b[6:0]; end
      8'ha8: if (a[5:0] >= 15) mx = a[5:0];
      8'hc0, 8'hc8: scn = o[3];
      8'hd3: off = a[5:0];
      8'hda: begin alt = a[4]; lr = a[5]; end
      8'hd5: begin dv = a[3:0]; osc = a[7:4]; end
      8'hd9: begin
        if (a[3:0] != 0) p1 = a[3:0];
        if (a[7:4] != 0) p2 = a[7:4];
      end
      8'hdb: if (a[6:4] inside {0, 2, 3}) vc = a[6:4];
      default: ;
    endcase
    check_all();
  endtask

  task automatic mapchk(input int r);
    row_i <= r[5:0];
    @(posedge clk_i);
    #1;
    if (r >= fx && r < fx + sr)
      chk(mem_row_o, fx + (r - fx - so + sr) % sr);
    else
      chk(mem_row_o, r);
    @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    scroll_step_i = 1'b0;
    row_i = 6'h00;
    rs = 32'h7327;
    tbl = '{8'h20, 8'h21, 8'h22, 8'ha0, 8'ha1, 8'ha8, 8'hc0, 8'hc8,
            8'hd3, 8'hda, 8'hd5, 8'hd9, 8'hdb, 8'he3};
    {md, ce, pge, mx, alt, osc, p1, p2, vc, sr} = {32'd2, 32'd127, 32'd7,
      32'd63, 32'd1, 32'd8, 32'd2, 32'd2, 32'd2, 32'd64};
    {pc, ps, cs, pgs, sl, seg, scn, off, lr, dv, fx, so} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check_all();
    cmd(8'ha3, 8'h08, 8'h30);
    for (int k = 0; k < 50; k++) begin
      for (int r = 0; r < 64; r += 5) mapchk(r);
      scroll_step_i <= 1'b1;
      @(posedge clk_i);
      scroll_step_i <= 1'b0;
      so = (so + 1) % sr;
    end
    cmd(8'ha3, 8'h00, 8'h10);
    for (int m = 0; m < 4; m++) cmd(8'h20, m[7:0], 8'h00);
    cmd(8'ha8, 8'h0e, 8'h00);
    cmd(8'ha8, 8'h0f, 8'h00);
    cmd(8'hd9, 8'h30, 8'h00);
    cmd(8'hd9, 8'h05, 8'h00);
    for (int v = 0; v < 8; v++) cmd(8'hdb, {v[3:0], 4'h0}, 8'h00);
    cmd(8'h21, 8'hb3, 8'h45);
    cmd(8'he3, 8'h00, 8'h00);
    cmd(8'h26, 8'h7f, 8'h7f);
    cmd(8'h2a, 8'hb5, 8'h7f);
    cmd(8'h81, 8'h7f, 8'h00);
    cmd(8'h8d, 8'h05, 8'h00);
    for (int i = 0; i < 80; i++) begin
      t = rb();
      case (i % 4)
        0: op = {3'b000, t[4:0]};
        1: op = {4'b0100, t[3:0]};
        2: op = {5'b10110, t[2:0]};
        default: op = tbl[t % 14];
      endcase
      cmd(op, rb(), rb());
    end
    host_u.xfer(1'b0, 8'h04, 32'h0, q);
    chk(q, {8'h0, md[1:0], pge[2:0], pgs[2:0], 1'b0, ce[6:0], 1'b0,
            cs[6:0]});
    host_u.xfer(1'b1, 8'h04, 32'hffffffff, q);
    host_u.xfer(1'b0, 8'h04, 32'h0, q);
    chk(q, {8'h0, md[1:0], pge[2:0], pgs[2:0], 1'b0, ce[6:0], 1'b0,
            cs[6:0]});
    host_u.xfer(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    host_u.xfer(1'b0, 8'h00, 32'h0, q);
    chk(q, {16'h0, 1'b0, ps[2:0], 4'h0, pc[7:0]});
    host_u.xfer(1'b0, 8'h08, 32'h0, q);
    chk(q, {10'h0, lr[0], alt[0], off[5:0], scn[0], mx[5:0], seg[0],
            sl[5:0]});
    host_u.xfer(1'b0, 8'h0c, 32'h0, q);
    chk(q, {13'h0, vc[2:0], p2[3:0], p1[3:0], osc[3:0], dv[3:0]});
    host_u.xfer(1'b0, 8'h10, 32'h0, q);
    chk(q, {13'h0, so[5:0], sr[6:0], fx[5:0]});
    check_all();
    complete_run();
  end
endmodule // test_display_config_command_decoder
